//--- pss_pkg_sync.sv
/*
  Shared constants and pin carrier type for the panel scan and sampling
  control block, and the two-flop input synchroniser it uses.
  Assumes a single 40 MHz core clock with a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

package pss_pkg;
  localparam int CLK_PERIOD_NS = 25;
  // Sample-and-hold disable time after the output latch
  localparam int DIS_TIME_NS = 8000;
  localparam int DIS_CYC_INT = (DIS_TIME_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
  localparam logic [8:0] DIS_CYC = 9'(DIS_CYC_INT);
  localparam logic [8:0] COL_FIRST = 9'h000;
  localparam logic [8:0] COL_LAST = 9'h1df;
  localparam logic [7:0] ROW_FIRST = 8'h00;
  localparam logic [7:0] ROW_LAST = 8'he9;
  localparam logic [2:0] MASK_NONE = 3'h0;
  localparam logic [2:0] MASK_A = 3'h1;
  localparam logic [2:0] MASK_B = 3'h2;
  localparam logic [2:0] MASK_C = 3'h4;
  localparam logic [2:0] MASK_ALL = 3'h7;
  localparam logic BANK_RST = 1'b0;

  typedef struct packed {
    logic supplies;
    logic hdir;
    logic vdir;
    logic mode;
    logic phase_a;
    logic phase_b;
    logic phase_c;
    logic latch;
    logic row_oe;
    logic row_clk;
    logic frame;
    logic left_in;
    logic right_in;
  } pss_pins_type;

  localparam pss_pins_type PINS_RST = '0;

  typedef enum logic [1:0] {
    PSS_IDLE = 2'b00,
    PSS_SAMPLE_A = 2'b01,
    PSS_SAMPLE_B = 2'b10,
    PSS_SAMPLE_C = 2'b11
  } pss_col_state_type;
endpackage

module pss_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

`default_nettype wire

//--- pss_panel.sv
/*
  Panel-side scan and sampling logic: column sampler with line start
  cascade, output latch handling, row scanner, and protocol monitors.
  Assumes all panel pins are asynchronous to core_clk and that the
  external timing controller drives phases no faster than the clock
  can resolve (each level lasts at least three core clocks).
*/
// Summary of operation
// - Horizontal select high drives the left start pin, low the right one.
// - Sampling select high samples all colours on phase a, low one per phase.
// - A latch rise swaps the sample-and-hold bank and drives the new line.
// - A high latch holds the column shift reset and lasts one sample period.
// - Row outputs are enabled only while the row output enable is high.
// - Rows step on the row shift clock and restart at a frame start.
// - Either start pin carries line start; direction picks the input.
`timescale 1ns/1ps
`default_nettype none

module pss_panel
  import pss_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic supplies_on,
  input wire logic scan_right_sel,
  input wire logic scan_down_sel,
  input wire logic sampling_method_select,
  input wire logic sample_clock_phase_a,
  input wire logic sample_clock_phase_b,
  input wire logic sample_clock_phase_c,
  input wire logic source_output_latch,
  input wire logic row_output_enable,
  input wire logic row_shift_clk,
  input wire logic frame_start_pulse,
  input wire logic left_line_start_i,
  output logic left_line_start_o,
  output logic left_line_start_oe,
  input wire logic right_line_start_i,
  output logic right_line_start_o,
  output logic right_line_start_oe,
  input wire logic err_clear,
  output logic sample_strobe,
  output logic [2:0] sample_color_mask,
  output logic [8:0] sample_column,
  output logic hold_bank,
  output logic column_drive_active,
  output logic [7:0] row_index,
  output logic row_active,
  output logic row_drive_en,
  output logic latch_width_err,
  output logic disable_time_err,
  output logic phase_hold_err
);
  pss_pins_type pins_raw;
  pss_pins_type pins_s;
  pss_pins_type pins_p_q;
  pss_col_state_type col_state_q, col_state_d;
  logic [8:0] col_cnt_q, col_cnt_d;
  logic start_out_q, start_out_d;
  logic strobe_q, left_oe_q, right_oe_q;
  logic [2:0] mask_q;
  logic [8:0] column_q;
  logic bank_q, drive_q, latch_seen_q;
  logic [8:0] dis_cnt_q;
  logic [7:0] row_q;
  logic row_act_q, row_en_q;
  logic lw_err_q, dt_err_q, ph_err_q;

  assign pins_raw = '{supplies: supplies_on, hdir: scan_right_sel,
    vdir: scan_down_sel, mode: sampling_method_select,
    phase_a: sample_clock_phase_a, phase_b: sample_clock_phase_b,
    phase_c: sample_clock_phase_c, latch: source_output_latch,
    row_oe: row_output_enable, row_clk: row_shift_clk,
    frame: frame_start_pulse, left_in: left_line_start_i,
    right_in: right_line_start_i};

  pss_sync #(.W($bits(pss_pins_type))) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .d(pins_raw),
    .q(pins_s)
  );

  // Edge detection on the synchronised copies only
  always_ff @(posedge core_clk) begin
    if (!rst_n) pins_p_q <= PINS_RST;
    else pins_p_q <= pins_s;
  end

  wire pwr = pins_s.supplies;
  wire rise_a = pins_s.phase_a & ~pins_p_q.phase_a;
  wire rise_b = pins_s.phase_b & ~pins_p_q.phase_b;
  wire rise_c = pins_s.phase_c & ~pins_p_q.phase_c;
  wire tog_bc = (pins_s.phase_b ^ pins_p_q.phase_b)
              | (pins_s.phase_c ^ pins_p_q.phase_c);
  wire latch_rise = pins_s.latch & ~pins_p_q.latch;
  wire latch_fall = ~pins_s.latch & pins_p_q.latch;
  wire row_rise = pins_s.row_clk & ~pins_p_q.row_clk;
  // Input pin is the right one when the select is high
  wire start_in = pins_s.hdir ? pins_s.right_in : pins_s.left_in;
  wire start_prev = pins_s.hdir ? pins_p_q.right_in : pins_p_q.left_in;
  wire start_rise = start_in & ~start_prev;

  // Column sampler decode
  wire in_a = (col_state_q == PSS_SAMPLE_A) & rise_a;
  wire in_b = (col_state_q == PSS_SAMPLE_B) & rise_b & ~pins_s.mode;
  wire in_c = (col_state_q == PSS_SAMPLE_C) & rise_c & ~pins_s.mode;
  wire stb_w = pwr & ~pins_s.latch & (in_a | in_b | in_c);
  wire [2:0] mask_w = in_a ? (pins_s.mode ? MASK_ALL : MASK_A)
                    : in_b ? MASK_B : in_c ? MASK_C : MASK_NONE;
  wire adv_w = stb_w & (in_c | (in_a & pins_s.mode));
  wire at_last = (col_cnt_q == COL_LAST);
  wire [8:0] phys_col = pins_s.hdir ? 9'(COL_LAST - col_cnt_q) : col_cnt_q;

  always_comb begin
    col_state_d = col_state_q;
    col_cnt_d = col_cnt_q;
    start_out_d = start_out_q & ~rise_a;
    if (!pwr || pins_s.latch) begin
      // Latch high holds the column shift register in reset
      col_state_d = PSS_IDLE;
      col_cnt_d = COL_FIRST;
      start_out_d = 1'b0;
    end else begin
      case (col_state_q)
        PSS_IDLE: begin
          if (rise_a && start_in) begin
            col_state_d = PSS_SAMPLE_A;
            col_cnt_d = COL_FIRST;
          end
        end
        PSS_SAMPLE_A: begin
          if (in_a) col_state_d = pins_s.mode ? PSS_SAMPLE_A : PSS_SAMPLE_B;
        end
        PSS_SAMPLE_B: begin
          if (in_b) col_state_d = PSS_SAMPLE_C;
        end
        PSS_SAMPLE_C: begin
          if (in_c) col_state_d = PSS_SAMPLE_A;
        end
        default: col_state_d = PSS_IDLE;
      endcase
      if (adv_w) begin
        if (at_last) begin
          // Cascade the start pulse out of the far pin
          col_state_d = PSS_IDLE;
          start_out_d = 1'b1;
        end else begin
          col_cnt_d = 9'(col_cnt_q + 9'h001);
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      col_state_q <= PSS_IDLE;
      col_cnt_q <= COL_FIRST;
      start_out_q <= 1'b0;
      strobe_q <= 1'b0;
      mask_q <= MASK_NONE;
      column_q <= COL_FIRST;
    end else begin
      col_state_q <= col_state_d;
      col_cnt_q <= col_cnt_d;
      start_out_q <= start_out_d;
      strobe_q <= stb_w;
      mask_q <= mask_w;
      column_q <= phys_col;
    end
  end

  // Pin direction; nothing driven before supplies are on
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      left_oe_q <= 1'b0;
      right_oe_q <= 1'b0;
    end else begin
      left_oe_q <= pwr & pins_s.hdir;
      right_oe_q <= pwr & ~pins_s.hdir;
    end
  end

  // Latch: bank swap on rise, width and disable-time monitors
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bank_q <= BANK_RST;
      drive_q <= 1'b0;
      latch_seen_q <= 1'b0;
      dis_cnt_q <= 9'h000;
      lw_err_q <= 1'b0;
      dt_err_q <= 1'b0;
      ph_err_q <= 1'b0;
    end else if (!pwr) begin
      drive_q <= 1'b0;
      latch_seen_q <= 1'b0;
      dis_cnt_q <= 9'h000;
    end else begin
      if (latch_rise) bank_q <= ~bank_q;
      if (latch_rise) drive_q <= 1'b1;
      if (latch_rise) latch_seen_q <= 1'b0;
      else if (pins_s.latch && rise_a) latch_seen_q <= 1'b1;
      if (latch_fall) dis_cnt_q <= DIS_CYC;
      else if (dis_cnt_q != 9'h000) dis_cnt_q <= 9'(dis_cnt_q - 9'h001);
      // Set wins over a simultaneous clear
      lw_err_q <= (latch_fall & ~latch_seen_q) | (lw_err_q & ~err_clear);
      dt_err_q <= (start_rise & (dis_cnt_q != 9'h000))
                | (dt_err_q & ~err_clear);
      ph_err_q <= (pins_s.mode & tog_bc) | (ph_err_q & ~err_clear);
    end
  end

  // Row scanner
  wire [7:0] row_start = pins_s.vdir ? ROW_FIRST : ROW_LAST;
  wire row_end = pins_s.vdir ? (row_q == ROW_LAST) : (row_q == ROW_FIRST);
  wire [7:0] row_step = pins_s.vdir ? 8'(row_q + 8'h01) : 8'(row_q - 8'h01);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      row_q <= ROW_FIRST;
      row_act_q <= 1'b0;
      row_en_q <= 1'b0;
    end else begin
      if (!pwr) begin
        row_act_q <= 1'b0;
      end else if (row_rise) begin
        if (pins_s.frame) begin
          row_q <= row_start;
          row_act_q <= 1'b1;
        end else if (row_act_q) begin
          row_q <= row_step;
          row_act_q <= ~row_end;
        end
      end
      row_en_q <= pwr & pins_s.row_oe & row_act_q;
    end
  end

  assign left_line_start_o = start_out_q;
  assign right_line_start_o = start_out_q;
  assign left_line_start_oe = left_oe_q;
  assign right_line_start_oe = right_oe_q;
  assign sample_strobe = strobe_q;
  assign sample_color_mask = mask_q;
  assign sample_column = column_q;
  assign hold_bank = bank_q;
  assign column_drive_active = drive_q;
  assign row_index = row_q;
  assign row_active = row_act_q;
  assign row_drive_en = row_en_q;
  assign latch_width_err = lw_err_q;
  assign disable_time_err = dt_err_q;
  assign phase_hold_err = ph_err_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence seq_latch_rise;
    pwr && latch_rise;
  endsequence

  chk_latch_bank_swap: assert property (
    seq_latch_rise |=> (bank_q != $past(bank_q)) && drive_q)
    else $error("bank not swapped on latch rise");
  chk_latch_holds_reset: assert property (
    pins_s.latch |=> col_state_q == PSS_IDLE && col_cnt_q == COL_FIRST
      && !strobe_q)
    else $error("column shift not held during latch");
  chk_simul_mask: assert property (
    stb_w && pins_s.mode |=> sample_strobe && sample_color_mask == MASK_ALL)
    else $error("simultaneous sample not all colours");
  chk_seq_mask: assert property (
    sample_strobe && !$past(pins_s.mode) |-> $onehot(sample_color_mask))
    else $error("sequential sample not one colour");
  chk_start_pin_dir: assert property (
    ##1 1 |-> left_line_start_oe == $past(pwr && pins_s.hdir)
      && right_line_start_oe == $past(pwr && !pins_s.hdir))
    else $error("start pin direction wrong");
  chk_row_enable: assert property (
    !pins_s.row_oe |=> !row_drive_en)
    else $error("row outputs enabled while enable low");
  chk_frame_start: assert property (
    pwr && row_rise && pins_s.frame |=> row_active
      && row_index == $past(row_start))
    else $error("frame start did not restart rows");
  chk_disable_timer: assert property (
    pwr && latch_fall |=> dis_cnt_q == DIS_CYC ##1
      dis_cnt_q == 9'(DIS_CYC - 9'h001) || !pwr || latch_fall)
    else $error("disable timer not loaded");
  chk_phase_hold: assert property (
    pwr && pins_s.mode && tog_bc |=> phase_hold_err [*2])
    else $error("phase toggle in simultaneous mode not flagged");
  chk_power_quiet: assert property (
    !pwr |=> !left_line_start_oe && !right_line_start_oe && !sample_strobe)
    else $error("activity before supplies on");
endmodule

`default_nettype wire

//--- pss_ctl_model.sv
/*
  Behavioural model of the external timing controller driving the panel.
  Assumes one bench process calls its tasks, all timed on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module pss_ctl_model
  import pss_pkg::*;
#(
  parameter int PH_HALF = 4,
  parameter int ROW_HALF = 20
) (
  input wire logic core_clk,
  input wire logic supplies,
  input wire logic simul,
  output logic [2:0] phase,
  output logic latch,
  output logic start,
  output logic row_clk,
  output logic frame
);
  // Set by the bench only to break the controller's own obligations
  logic rogue;
  int dis_cnt;

  initial begin
    rogue = 1'b0;
    phase = '0;
    latch = 1'b0;
    start = 1'b0;
    row_clk = 1'b0;
    frame = 1'b0;
    dis_cnt = 1000;
  end

  always @(posedge core_clk) begin
    if (latch)
      dis_cnt <= 0;
    else if (dis_cnt < 1000)
      dis_cnt <= dis_cnt + 1;
  end

  // Counter-timed half periods
  task automatic pulse(input int i);
    if ((supplies || rogue) && (!simul || i == 0 || rogue)) begin
      @(posedge core_clk);
      phase[i] <= 1'b1;
      repeat (PH_HALF) @(posedge core_clk);
      phase[i] <= 1'b0;
      repeat (PH_HALF) @(posedge core_clk);
    end
  endtask

  // Margin covers the panel's input synchroniser delay
  task automatic line_start();
    while (!rogue && dis_cnt < DIS_CYC_INT + 8) @(posedge core_clk);
    @(posedge core_clk);
    start <= supplies || rogue;
    pulse(0);
    start <= 1'b0;
  endtask

  // A full latch spans one sample clock period
  task automatic latch_pulse();
    @(posedge core_clk);
    latch <= 1'b1;
    if (!rogue)
      pulse(0);
    else
      repeat (2) @(posedge core_clk);
    latch <= 1'b0;
    repeat (PH_HALF) @(posedge core_clk);
  endtask

  // Frame start set up and held around the shift clock rise
  task automatic row_step(input logic f);
    @(posedge core_clk);
    frame <= f;
    repeat (ROW_HALF) @(posedge core_clk);
    row_clk <= 1'b1;
    repeat (ROW_HALF) @(posedge core_clk);
    row_clk <= 1'b0;
    frame <= 1'b0;
    repeat (ROW_HALF) @(posedge core_clk);
  endtask
endmodule

`default_nettype wire

//--- panel_scan_sampling_control_tb.sv
/*
  Self-checking bench for the panel scan and sampling block.
  Assumes the controller model stands on the panel pins.
*/
`timescale 1ns/1ps
`default_nettype none

module panel_scan_sampling_control_tb;
  logic core_clk, rst_n, supplies, hdir, vdir, mode, row_oe, err_clear;
  logic [2:0] ph;
  logic latch, start, row_clk, frame, wiggle, lo, loe, ro, roe, strobe;
  logic bank, cda, ract, rden, lwe, dte, phe, bank0;
  logic [2:0] mask, last_mask;
  logic [8:0] col, last_col;
  logic [7:0] row;
  int num_errors, n_tests, n_strobe, cycles, base;
  // Undriven pin shows a changing pattern, not a stale level
  wire logic lpin = loe ? lo : (!hdir ? start : wiggle);
  wire logic rpin = roe ? ro : (hdir ? start : wiggle);

  pss_ctl_model pss_ctl_model_inst (.core_clk(core_clk), .supplies(supplies),
    .simul(mode), .phase(ph), .latch(latch), .start(start),
    .row_clk(row_clk), .frame(frame));

  pss_panel pss_panel_inst (.core_clk(core_clk), .rst_n(rst_n),
    .supplies_on(supplies), .scan_right_sel(hdir), .scan_down_sel(vdir),
    .sampling_method_select(mode), .sample_clock_phase_a(ph[0]),
    .sample_clock_phase_b(ph[1]), .sample_clock_phase_c(ph[2]),
    .source_output_latch(latch), .row_output_enable(row_oe),
    .row_shift_clk(row_clk), .frame_start_pulse(frame),
    .left_line_start_i(lpin), .left_line_start_o(lo),
    .left_line_start_oe(loe), .right_line_start_i(rpin),
    .right_line_start_o(ro), .right_line_start_oe(roe),
    .err_clear(err_clear), .sample_strobe(strobe), .sample_color_mask(mask),
    .sample_column(col), .hold_bank(bank), .column_drive_active(cda),
    .row_index(row), .row_active(ract), .row_drive_en(rden),
    .latch_width_err(lwe), .disable_time_err(dte), .phase_hold_err(phe));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    wiggle <= ~wiggle;
    cycles <= cycles + 1;
    if (strobe === 1'b1) begin
      last_mask <= mask;
      last_col <= col;
      n_strobe <= n_strobe + 1;
    end
    if (cycles == 20000) begin
      num_errors++;
      complete_run();
    end
  end

  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic clear_errs();
    err_clear <= 1'b1;
    tick(6);
    err_clear <= 1'b0;
    tick(2);
  endtask

  task automatic complete_run();
    if (num_errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    {rst_n, supplies, hdir, mode, row_oe, err_clear, wiggle} = '0;
    vdir = 1'b1;
    {num_errors, n_tests, n_strobe, cycles} = '0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    tick(4);
    // Supplies off: pins are ignored, nothing driven
    pss_ctl_model_inst.rogue = 1'b1;
    pss_ctl_model_inst.line_start();
    pss_ctl_model_inst.pulse(0);
    pss_ctl_model_inst.rogue = 1'b0;
    tick(2);
    chk(9'(n_strobe), 9'h000);
    chk({7'h00, loe, roe}, 9'h000);
    supplies <= 1'b1;
    tick(6);
    chk({7'h00, loe, roe}, 9'h001);
    hdir <= ~hdir;
    tick(6);
    chk({7'h00, loe, roe}, 9'h002);
    hdir <= ~hdir;
    tick(6);
    pss_ctl_model_inst.line_start();
    base = n_strobe;
    for (int i = 0; i < 4; i++) begin
      pss_ctl_model_inst.pulse(i % 3);
      chk(9'(last_mask), 9'(1 << (i % 3)));
      chk(last_col, 9'(i / 3));
    end
    bank0 = bank;
    pss_ctl_model_inst.latch_pulse();
    tick(2);
    chk({6'h00, bank, cda, lwe}, {6'h00, ~bank0, 2'b10});
    chk(9'(n_strobe - base), 9'h004);
    pss_ctl_model_inst.rogue = 1'b1;
    pss_ctl_model_inst.latch_pulse();
    pss_ctl_model_inst.rogue = 1'b0;
    tick(6);
    chk({8'h00, lwe}, 9'h001);
    pss_ctl_model_inst.latch_pulse();
    pss_ctl_model_inst.rogue = 1'b1;
    pss_ctl_model_inst.line_start();
    pss_ctl_model_inst.rogue = 1'b0;
    tick(6);
    chk({8'h00, dte}, 9'h001);
    clear_errs();
    chk({6'h00, lwe, dte, phe}, 9'h000);
    pss_ctl_model_inst.latch_pulse();
    pss_ctl_model_inst.line_start();
    tick(6);
    chk({8'h00, dte}, 9'h000);
    // Return the armed sampler to idle before the next line
    pss_ctl_model_inst.latch_pulse();
    mode <= ~mode;
    hdir <= ~hdir;
    tick(6);
    pss_ctl_model_inst.line_start();
    base = n_strobe;
    for (int i = 0; i < 480; i++) begin
      pss_ctl_model_inst.pulse(0);
      if (i == 0)
        chk({last_mask, last_col[5:0]}, {3'h7, 6'h1f});
    end
    chk(last_col, 9'h000);
    chk(9'(n_strobe - base), 9'h1e0);
    chk({6'h00, loe, lo, ro}, 9'h007);
    pss_ctl_model_inst.rogue = 1'b1;
    pss_ctl_model_inst.pulse(1);
    pss_ctl_model_inst.rogue = 1'b0;
    tick(6);
    chk({8'h00, phe}, 9'h001);
    chk(9'(n_strobe - base), 9'h1e0);
    pss_ctl_model_inst.row_step(1'b1);
    chk({ract, row}, 9'h100);
    row_oe <= ~row_oe;
    tick(6);
    chk({8'h00, rden}, 9'h001);
    row_oe <= ~row_oe;
    pss_ctl_model_inst.row_step(1'b0);
    chk({rden, row}, 9'h001);
    vdir <= ~vdir;
    pss_ctl_model_inst.row_step(1'b1);
    chk({ract, row}, 9'h1e9);
    pss_ctl_model_inst.row_step(1'b0);
    chk({ract, row}, 9'h1e8);
    supplies <= ~supplies;
    tick(6);
    chk({5'h00, ract, cda, loe, roe}, 9'h000);
    // Mid-run reset, then a sequential line scanned right to left
    rst_n <= 1'b0;
    tick(3);
    rst_n <= 1'b1;
    supplies <= ~supplies;
    mode <= ~mode;
    tick(6);
    chk({5'h00, bank, phe, loe, roe}, 9'h002);
    pss_ctl_model_inst.line_start();
    pss_ctl_model_inst.pulse(0);
    chk({last_mask, last_col[5:0]}, {3'h1, 6'h1f});
    complete_run();
  end
endmodule

`default_nettype wire
